// file: rtl/ips_timing_regs.vh
// Purpose: timing constants and encodings for the input power-up sequencer
// Assumes: 125 MHz clock, 8 ns period
// Notes:   times kept in their printed unit, cycle counts derived here
`ifndef IPS_TIMING_REGS_VH
`define IPS_TIMING_REGS_VH

`define IPS_CLK_MHZ          125
`define IPS_POORSRC_MS       30
`define IPS_POORSRC_RETRY_S  2
`define IPS_DEB_MS           15
`define IPS_BIAS_DLY_MS      220
`define IPS_DCD_ON_MS        13
`define IPS_DCD_WAIT_MS      500
`define IPS_DET_MS           40

`define IPS_MS_CYC(ms)       ((ms) * 1000 * `IPS_CLK_MHZ)
`define IPS_S_CYC(s)         ((s) * 1000 * 1000 * `IPS_CLK_MHZ)

// adapter type codes
`define IPS_TYPE_NONE        4'h0
`define IPS_TYPE_SDP         4'h1
`define IPS_TYPE_CDP         4'h2
`define IPS_TYPE_DCP         4'h3
`define IPS_TYPE_DIV1        4'h4
`define IPS_TYPE_DIV2        4'h5
`define IPS_TYPE_DIV3        4'h6
`define IPS_TYPE_DIV4        4'h7
`define IPS_TYPE_UNKNOWN     4'h8

// input current limit codes, in units of 100 mA
`define IPS_LIM_SDP          6'h05
`define IPS_LIM_CDP          6'h0F
`define IPS_LIM_DCP          6'h18
`define IPS_LIM_DIV1         6'h15
`define IPS_LIM_DIV2         6'h14
`define IPS_LIM_DIV3         6'h0A
`define IPS_LIM_DIV4         6'h18
`define IPS_LIM_PIN          6'h00

// divider window bits: [0] 1.2 V, [1] 2.0 V, [2] 2.8 V
`define IPS_WIN_1P2          2'd0
`define IPS_WIN_2P0          2'd1
`define IPS_WIN_2P8          2'd2

`endif

// file: rtl/ips_timer.v
// Purpose: loadable down-counting timer with expiry pulse
// Assumes: start pulse reloads, clear stops
// Notes:   done is a one-cycle pulse when the count reaches its end
`timescale 1ns/1ns
`default_nettype none
module ips_timer #(
  parameter W = 32
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // control
  input  wire         start,
  input  wire         clear,
  input  wire [W-1:0] load,
  // status
  output reg          busy,
  output reg          done
);
  reg [W-1:0] cnt_r; // cycles left

  // count down while busy, pulse done at the last cycle
  always @(posedge clk) begin
    if (rst || clear) begin
      cnt_r <= {W{1'b0}};
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (start) begin
      cnt_r <= load;
      busy  <= 1'b1;
      done  <= 1'b0;
    end else if (busy) begin
      if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
        busy <= 1'b0;
        done <= 1'b1;
      end else begin
        cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        done  <= 1'b0;
      end
    end else begin
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: rtl/ips_classify.v
// Purpose: map adapter type and divider windows to current limit code
// Assumes: window inputs are comparator levels, synchronous to clk
// Notes:   purely combinational
`timescale 1ns/1ns
`default_nettype none
`include "ips_timing_regs.vh"
module ips_classify (
  // divider window comparators, one bit per window
  input  wire [2:0] dp_win,
  input  wire [2:0] dm_win,
  // result of standard detection
  input  wire [3:0] std_type,
  // outputs
  output reg  [3:0] div_type,
  output reg  [5:0] lim_code
);
  // divider window decode
  always @* begin
    if (dp_win[`IPS_WIN_2P8] && dm_win[`IPS_WIN_2P0])
      div_type = `IPS_TYPE_DIV1;
    else if (dp_win[`IPS_WIN_1P2] && dm_win[`IPS_WIN_1P2])
      div_type = `IPS_TYPE_DIV2;
    else if (dp_win[`IPS_WIN_2P0] && dm_win[`IPS_WIN_2P8])
      div_type = `IPS_TYPE_DIV3;
    else if (dp_win[`IPS_WIN_2P8] && dm_win[`IPS_WIN_2P8])
      div_type = `IPS_TYPE_DIV4;
    else
      div_type = `IPS_TYPE_UNKNOWN;
  end

  // type to limit table
  always @* begin
    case (std_type)
      `IPS_TYPE_SDP:  lim_code = `IPS_LIM_SDP;
      `IPS_TYPE_CDP:  lim_code = `IPS_LIM_CDP;
      `IPS_TYPE_DCP:  lim_code = `IPS_LIM_DCP;
      `IPS_TYPE_DIV1: lim_code = `IPS_LIM_DIV1;
      `IPS_TYPE_DIV2: lim_code = `IPS_LIM_DIV2;
      `IPS_TYPE_DIV3: lim_code = `IPS_LIM_DIV3;
      `IPS_TYPE_DIV4: lim_code = `IPS_LIM_DIV4;
      default:        lim_code = `IPS_LIM_PIN;
    endcase
  end
endmodule
`default_nettype wire

// file: rtl/ips_sequencer.v
// Purpose: power-up sequencer for input source and battery-only start
// Assumes: all comparator inputs are synchronous levels to clk
// Notes:   surge path is combinational so switches drop at once
`timescale 1ns/1ns
`default_nettype none
`include "ips_timing_regs.vh"
module ips_sequencer #(
  parameter [31:0] DEB_CYC   = `IPS_MS_CYC(`IPS_DEB_MS),
  parameter [31:0] BIAS_CYC  = `IPS_MS_CYC(`IPS_BIAS_DLY_MS),
  parameter [31:0] POOR_CYC  = `IPS_MS_CYC(`IPS_POORSRC_MS),
  parameter [31:0] RETRY_CYC = `IPS_S_CYC(`IPS_POORSRC_RETRY_S),
  parameter [31:0] DCDON_CYC = `IPS_MS_CYC(`IPS_DCD_ON_MS),
  parameter [31:0] DCDW_CYC  = `IPS_MS_CYC(`IPS_DCD_WAIT_MS),
  parameter [31:0] DET_CYC   = `IPS_MS_CYC(`IPS_DET_MS)
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // supply comparators
  input  wire       input_uvlo_release,
  input  wire       battery_uvlo_release,
  input  wire       battery_depletion_release,
  input  wire       adapter_present,
  input  wire       adapter_overvoltage,
  input  wire       sleep_exit_margin,
  input  wire       input_surge,
  input  wire       discharge_overcurrent,
  input  wire       poor_source_ok,
  // modes
  input  wire       boost_mode,
  input  wire       high_impedance_mode,
  // data line comparators
  input  wire       dp_low,
  input  wire       dm_below_ref,
  input  wire       dp_below_ref,
  input  wire [2:0] dp_win,
  input  wire [2:0] dm_win,
  // switch and bias controls
  output wire       bias_active,
  output reg        battery_switch,
  output wire       input_protect_switch,
  output reg        bias_regulator,
  output reg        poor_source_test_load,
  output wire       converter_en,
  output reg        input_source_good,
  // data line drivers
  output reg        dp_cur_src,
  output reg        dm_pulldown,
  output reg        dp_volt_src,
  output reg        dm_cur_sink,
  output reg        dm_volt_src,
  output reg        dp_cur_sink,
  // results
  output reg  [3:0] adapter_type,
  output reg  [5:0] input_current_limit,
  output reg        input_voltage_limit_set
);
  // sequence states
  localparam [3:0] S_IDLE   = 4'h0; // no valid input
  localparam [3:0] S_DEB    = 4'h1; // protection switch debounce
  localparam [3:0] S_BIAS   = 4'h2; // bias regulator delay
  localparam [3:0] S_POOR   = 4'h3; // test load applied
  localparam [3:0] S_RETRY  = 4'h4; // wait before retry
  localparam [3:0] S_DCD    = 4'h5; // contact detection
  localparam [3:0] S_PRI    = 4'h6; // primary detection
  localparam [3:0] S_SEC    = 4'h7; // secondary detection
  localparam [3:0] S_VLIM   = 4'h8; // voltage limit step
  localparam [3:0] S_RUN    = 4'h9; // converter running

  reg  [3:0]  state_r;      // current state
  reg  [3:0]  state_nxt;    // next state
  reg         acsw_r;       // protection switch held on
  reg         conv_r;       // converter enable held
  reg         ocp_lock_r;   // battery switch latched open
  reg         plug_d_r;     // previous adapter window level
  reg  [3:0]  std_type_r;   // detected type
  reg         tmr_start;    // timer reload
  reg  [31:0] tmr_load;     // timer reload value
  reg         dcd_seen_r;   // contact seen in dcd phase
  wire        tmr_busy;     // timer running
  wire        tmr_done;     // timer expiry pulse
  wire [3:0]  div_type;     // divider classification
  wire [5:0]  lim_code;     // limit for latched type

  // adapter voltage inside present and overvoltage window
  wire in_window = adapter_present && !adapter_overvoltage;
  wire plug_rise = in_window && !plug_d_r;

  // bias mode condition: buck needs switch and margin, boost the opposite
  wire bias_cond = input_uvlo_release && !high_impedance_mode &&
                   (boost_mode ? !sleep_exit_margin
                               : (acsw_r && sleep_exit_margin));

  // comparators and battery switch driver alive on either rail
  assign bias_active = input_uvlo_release ||
                       battery_uvlo_release;

  // surge drops both switches combinationally
  assign input_protect_switch = acsw_r && !input_surge;
  assign converter_en         = conv_r && !input_surge;

  // shared phase timer
  ips_timer #(.W(32)) u_tmr (
    .clk   (clk),
    .rst   (rst),
    .start (tmr_start),
    .clear (1'b0),
    .load  (tmr_load),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  // classification and limit lookup
  ips_classify u_cls (
    .dp_win   (dp_win),
    .dm_win   (dm_win),
    .std_type (std_type_r),
    .div_type (div_type),
    .lim_code (lim_code)
  );

  // next state and timer loads
  always @* begin
    state_nxt = state_r;
    tmr_start = 1'b0;
    tmr_load  = 32'h0000_0000;
    if (!in_window || input_surge) begin
      state_nxt = S_IDLE; // source gone or surge: restart
    end else begin
      case (state_r)
        S_IDLE: begin
          state_nxt = S_DEB;
          tmr_start = 1'b1;
          tmr_load  = DEB_CYC;
        end
        S_DEB: begin
          if (tmr_done) begin
            state_nxt = S_BIAS;
          end
        end
        S_BIAS: begin
          if (!bias_cond) begin
            tmr_start = 1'b1; // hold off until conditions stand
            tmr_load  = BIAS_CYC;
          end else if (!tmr_busy && !tmr_done) begin
            tmr_start = 1'b1;
            tmr_load  = BIAS_CYC;
          end else if (tmr_done) begin
            state_nxt = S_POOR;
            tmr_start = 1'b1;
            tmr_load  = POOR_CYC;
          end
        end
        S_POOR: begin
          if (tmr_done) begin
            tmr_start = 1'b1;
            if (poor_source_ok) begin
              state_nxt = S_DCD;
              tmr_load  = DCDW_CYC;
            end else begin
              state_nxt = S_RETRY;
              tmr_load  = RETRY_CYC;
            end
          end
        end
        S_RETRY: begin
          if (tmr_done) begin
            state_nxt = S_POOR;
            tmr_start = 1'b1;
            tmr_load  = POOR_CYC;
          end
        end
        S_DCD: begin
          if (dcd_seen_r) begin
            state_nxt = S_PRI;
            tmr_start = 1'b1;
            tmr_load  = DET_CYC;
          end else if (tmr_done) begin
            state_nxt = S_VLIM;
          end
        end
        S_PRI: begin
          if (tmr_done) begin
            if (dm_below_ref) begin
              state_nxt = S_VLIM; // standard host
            end else begin
              state_nxt = S_SEC;
              tmr_start = 1'b1;
              tmr_load  = DET_CYC;
            end
          end
        end
        S_SEC: begin
          if (tmr_done) begin
            state_nxt = S_VLIM;
          end
        end
        S_VLIM: begin
          state_nxt = S_RUN;
        end
        S_RUN: begin
          state_nxt = S_RUN;
        end
        default: begin
          state_nxt = S_IDLE;
        end
      endcase
    end
  end

  // state, switches and detection results
  always @(posedge clk) begin
    if (rst) begin
      state_r               <= S_IDLE;
      acsw_r                <= 1'b0;
      conv_r                <= 1'b0;
      plug_d_r              <= 1'b0;
      std_type_r            <= `IPS_TYPE_NONE;
      dcd_seen_r            <= 1'b0;
      bias_regulator        <= 1'b0;
      poor_source_test_load <= 1'b0;
      input_source_good     <= 1'b0;
      dp_cur_src            <= 1'b0;
      dm_pulldown           <= 1'b0;
      dp_volt_src           <= 1'b0;
      dm_cur_sink           <= 1'b0;
      dm_volt_src           <= 1'b0;
      dp_cur_sink           <= 1'b0;
      adapter_type          <= `IPS_TYPE_NONE;
      input_current_limit   <= `IPS_LIM_PIN;
      input_voltage_limit_set <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      plug_d_r <= in_window;
      // protection switch closes after debounce, opens on surge
      if (state_nxt == S_IDLE || state_nxt == S_DEB)
        acsw_r <= 1'b0;
      else
        acsw_r <= 1'b1;
      // bias regulator only once delay passed in the right mode
      bias_regulator <= bias_cond &&
        (state_nxt >= S_POOR);
      // test load only during the check window
      poor_source_test_load <= (state_nxt == S_POOR);
      // qualification outcome
      if (state_nxt == S_IDLE)
        input_source_good <= 1'b0;
      else if (state_r == S_POOR && tmr_done && poor_source_ok)
        input_source_good <= 1'b1;
      // converter only after the whole sequence
      conv_r <= (state_nxt == S_RUN);
      input_voltage_limit_set <= (state_nxt == S_VLIM) ||
                                 (state_nxt == S_RUN);
      // contact phase drivers, held on from the first busy cycle until contact detection ends
      if (state_r == S_DCD && tmr_busy &&
          (DCDW_CYC - DCDON_CYC) > 32'h0) begin
        dp_cur_src  <= 1'b1;
        dm_pulldown <= 1'b1;
      end
      if (state_nxt != S_DCD) begin
        dp_cur_src  <= 1'b0;
        dm_pulldown <= 1'b0;
      end
      // contact seen when D+ pulled low while the source is on
      if (state_nxt != S_DCD)
        dcd_seen_r <= 1'b0;
      else if (dp_cur_src && dp_low)
        dcd_seen_r <= 1'b1;
      // primary and secondary drivers follow their states
      dp_volt_src <= (state_nxt == S_PRI);
      dm_cur_sink <= (state_nxt == S_PRI);
      dm_volt_src <= (state_nxt == S_SEC);
      dp_cur_sink <= (state_nxt == S_SEC);
      // capture type on leaving DCD for VLIM, PRI as host, or SEC; cleared on plug-in
      if (plug_rise) begin
        std_type_r <= `IPS_TYPE_NONE;
      end else if (state_r == S_DCD && state_nxt == S_VLIM) begin
        std_type_r <= div_type;
      end else if (state_r == S_PRI && tmr_done && dm_below_ref) begin
        std_type_r <= `IPS_TYPE_SDP;
      end else if (state_r == S_SEC && tmr_done) begin
        std_type_r <= dp_below_ref ? `IPS_TYPE_CDP
                                   : `IPS_TYPE_DCP;
      end
      // publish limit once the voltage limit step is reached
      if (state_r == S_VLIM) begin
        adapter_type        <= std_type_r;
        input_current_limit <= lim_code;
      end
    end
  end

  // battery switch: feeds system while bias active and battery not depleted, unless overcurrent latch set
  always @(posedge clk) begin
    if (rst) begin
      ocp_lock_r     <= 1'b0;
      battery_switch <= 1'b0;
    end else begin
      if (discharge_overcurrent)
        ocp_lock_r <= 1'b1;
      else if (plug_rise)
        ocp_lock_r <= 1'b0;
      battery_switch <= bias_active && battery_depletion_release &&
                        !discharge_overcurrent &&
                        !ocp_lock_r;
    end
  end
endmodule
`default_nettype wire

// file: tb/ips_seq_properties.sv
// Purpose: port checks for the input power-up sequencer
// Assumes: timing parameters equal those of the bound instance
// Notes:   bound to every ips_sequencer instance
`timescale 1ns/1ns
`default_nettype none
module ips_seq_properties #(
  parameter [31:0] DEB_CYC  = 32'h14,
  parameter [31:0] POOR_CYC = 32'h14,
  parameter [31:0] DET_CYC  = 32'h14
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // supply and mode inputs
  input wire logic       input_uvlo_release,
  input wire logic       battery_uvlo_release,
  input wire logic       adapter_present,
  input wire logic       adapter_overvoltage,
  input wire logic       input_surge,
  input wire logic       discharge_overcurrent,
  input wire logic       high_impedance_mode,
  // switch controls
  input wire logic       bias_active,
  input wire logic       battery_switch,
  input wire logic       input_protect_switch,
  input wire logic       bias_regulator,
  input wire logic       poor_source_test_load,
  input wire logic       converter_en,
  input wire logic       input_source_good,
  // data line drivers and result
  input wire logic       dp_cur_src,
  input wire logic       dm_pulldown,
  input wire logic       dp_volt_src,
  input wire logic       dm_cur_sink,
  input wire logic       dm_volt_src,
  input wire logic       dp_cur_sink,
  input wire logic [3:0] adapter_type
);
  wire         win = adapter_present & ~adapter_overvoltage;  // plug window
  logic [31:0] win_cnt_r;   // consecutive window cycles
  logic [31:0] load_cnt_r;  // consecutive test load cycles
  logic [31:0] pri_cnt_r;   // consecutive primary drive cycles

  // run-length counters, as wide as the timing parameters they meet
  always @(posedge clk) begin
    if (rst) begin
      win_cnt_r  <= 32'h0;
      load_cnt_r <= 32'h0;
      pri_cnt_r  <= 32'h0;
    end else begin
      win_cnt_r  <= win ? win_cnt_r + 32'h1 : 32'h0;
      load_cnt_r <= poor_source_test_load ? load_cnt_r + 32'h1 : 32'h0;
      pri_cnt_r  <= dp_volt_src ? pri_cnt_r + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // line driver pairs for each detection phase
  sequence dcd_drive; dp_cur_src && dm_pulldown; endsequence
  sequence pri_drive; dp_volt_src && dm_cur_sink; endsequence
  sequence sec_drive; dm_volt_src && dp_cur_sink; endsequence

  bias_wake_a: assert property (
    bias_active == (input_uvlo_release || battery_uvlo_release))
    else $error("bias wake mismatch");
  surge_cut_a: assert property (
    input_surge |-> !input_protect_switch && !converter_en)
    else $error("switch on during surge");
  debounce_a: assert property (
    $rose(input_protect_switch) |-> win_cnt_r >= DEB_CYC)
    else $error("protect switch before debounce");
  window_loss_a: assert property (
    !win |-> ##[0:2] !input_protect_switch)
    else $error("protect switch stays on off window");
  poor_len_a: assert property (
    $fell(poor_source_test_load) && $past(win) |->
      load_cnt_r >= POOR_CYC - 1 && load_cnt_r <= POOR_CYC + 2)
    else $error("test load length wrong");
  good_first_a: assert property (
    (dp_cur_src || dp_volt_src || dm_volt_src || converter_en)
      |-> input_source_good)
    else $error("detection or converter before pass");
  dcd_pair_a: assert property (
    $rose(dp_cur_src) |-> dcd_drive)
    else $error("contact drivers unpaired");
  pri_pair_a: assert property (
    $rose(dp_volt_src) |-> pri_drive)
    else $error("primary drivers unpaired");
  pri_len_a: assert property (
    $fell(dp_volt_src) && $past(win) |-> !dm_cur_sink &&
      pri_cnt_r >= DET_CYC - 1 && pri_cnt_r <= DET_CYC + 2)
    else $error("primary length wrong");
  sec_order_a: assert property (
    $rose(dm_volt_src) |->
      sec_drive ##0 ($past(dp_volt_src) || $past(dp_volt_src, 2)))
    else $error("secondary without primary");
  hiz_off_a: assert property (
    $rose(high_impedance_mode) |-> ##[1:2] !bias_regulator)
    else $error("bias on in high impedance");
  ocp_open_a: assert property (
    discharge_overcurrent |-> ##[0:2] !battery_switch)
    else $error("battery switch on in overcurrent");
  run_typed_a: assert property (
    $rose(converter_en) |-> adapter_type != 4'h0)
    else $error("converter before detection");
endmodule
bind ips_sequencer ips_seq_properties #(
  .DEB_CYC(DEB_CYC), .POOR_CYC(POOR_CYC), .DET_CYC(DET_CYC)
) i_ips_seq_properties (.*);
`default_nettype wire

// file: tb/ips_port_model.sv
// Purpose: usb port or adapter seen on the data lines
// Assumes: kind 0 none, 1 host, 2 cdp, 3 dcp, 4-7 divider 1-4
// Notes:   undriven comparators churn so no stale level reads true
`timescale 1ns/1ns
`default_nettype none
module ips_port_model (
  // clock
  input  wire logic       clk,
  // attached port and contact delay
  input  wire logic [2:0] kind,
  input  wire logic [5:0] contact_dly,
  // device line drivers
  input  wire logic       dp_cur_src,
  input  wire logic       dp_volt_src,
  input  wire logic       dm_cur_sink,
  input  wire logic       dm_volt_src,
  input  wire logic       dp_cur_sink,
  // comparator levels back to the device
  output var  logic       dp_low,
  output var  logic       dm_below_ref,
  output var  logic       dp_below_ref,
  output var  logic [2:0] dp_win,
  output var  logic [2:0] dm_win
);
  logic [5:0] dcd_cnt_r = 6'h00;  // cycles with d+ source on
  logic       tog_r     = 1'b0;   // churn for undriven lines
  wire        std = (kind != 3'd0) && (kind < 3'd4);  // bc1.2 port

  // count source time; contact may come late
  always @(posedge clk) begin
    tog_r     <= ~tog_r;
    dcd_cnt_r <= (dp_cur_src === 1'b1) ? dcd_cnt_r + 6'h01 : 6'h00;
  end

  // line answers
  always @* begin
    // pins touch after the delay and d+ drops
    dp_low = (dp_cur_src === 1'b1) ? (std && dcd_cnt_r >= contact_dly) : tog_r;
    // only a host port leaves d- low
    dm_below_ref = (dp_volt_src && dm_cur_sink) ? (kind == 3'd1) : tog_r;
    // only a cdp leaves d+ low
    dp_below_ref = (dm_volt_src && dp_cur_sink) ? (kind == 3'd2) : tog_r;
    // divider levels, d+ then d
    case (kind)
      3'd4: {dp_win, dm_win} = 6'h22;
      3'd5: {dp_win, dm_win} = 6'h09;
      3'd6: {dp_win, dm_win} = 6'h14;
      3'd7: {dp_win, dm_win} = 6'h24;
      default: {dp_win, dm_win} = 6'h00;
    endcase
  end
endmodule
`default_nettype wire

// file: tb/input_powerup_source_detect_tb.sv
// Purpose: self-checking bench for the input power-up sequencer
// Assumes: shortened timing counts set below
// Notes:   plugs every port kind, with random contact and retries
`timescale 1ns/1ns
`default_nettype none
`include "ips_timing_regs.vh"
module input_powerup_source_detect_tb;
  localparam int DEB = 20;    // debounce cycles
  localparam int BIAS = 30;   // bias delay cycles
  localparam int POOR = 20;   // test load cycles
  localparam int RETRY = 60;  // retry wait cycles
  logic clk = 1'b0, rst = 1'b1;
  logic input_uvlo_release = 1'b0, adapter_present = 1'b0;
  logic battery_uvlo_release = 1'b1, battery_depletion_release = 1'b1;
  logic adapter_overvoltage = 1'b0, sleep_exit_margin = 1'b1;
  logic input_surge = 1'b0, discharge_overcurrent = 1'b0;
  logic poor_source_ok = 1'b0, boost_mode = 1'b0;
  logic high_impedance_mode = 1'b0;
  logic [2:0] kind = 3'd0;         // port attached
  logic [5:0] contact_dly = 6'h00; // contact delay
  wire logic dp_low, dm_below_ref, dp_below_ref;
  wire logic [2:0] dp_win, dm_win;
  wire logic bias_active, battery_switch, input_protect_switch;
  wire logic bias_regulator, poor_source_test_load, converter_en;
  wire logic input_source_good, dp_cur_src, dm_pulldown, dp_volt_src;
  wire logic dm_cur_sink, dm_volt_src, dp_cur_sink;
  wire logic input_voltage_limit_set;
  wire logic [3:0] adapter_type;
  wire logic [5:0] input_current_limit;
  int err_count = 0, total_checks = 0, cyc = 0, k;
  integer seed;

  ips_sequencer #(
    .DEB_CYC(DEB), .BIAS_CYC(BIAS), .POOR_CYC(POOR), .RETRY_CYC(RETRY),
    .DCDON_CYC(10), .DCDW_CYC(80), .DET_CYC(20)
  ) i_ips_sequencer (.*);
  ips_port_model i_ips_port_model (.*);

  initial forever #4 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // status output chosen by index
  function automatic logic pick(input int s);
    case (s)
      0: pick = input_protect_switch;
      1: pick = bias_regulator;
      2: pick = poor_source_test_load;
      4: pick = converter_en;
      default: pick = ~poor_source_test_load;
    endcase
  endfunction

  // count falling edges until the output is high
  task automatic wt(input int s, output int n);
    n = 0;
    while (pick(s) !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask

  // type and limit code expected for a port kind
  function automatic logic [9:0] expect_of(input logic [2:0] p);
    case (p)
      3'd1: expect_of = {`IPS_TYPE_SDP, `IPS_LIM_SDP};
      3'd2: expect_of = {`IPS_TYPE_CDP, `IPS_LIM_CDP};
      3'd3: expect_of = {`IPS_TYPE_DCP, `IPS_LIM_DCP};
      3'd4: expect_of = {`IPS_TYPE_DIV1, `IPS_LIM_DIV1};
      3'd5: expect_of = {`IPS_TYPE_DIV2, `IPS_LIM_DIV2};
      3'd6: expect_of = {`IPS_TYPE_DIV3, `IPS_LIM_DIV3};
      3'd7: expect_of = {`IPS_TYPE_DIV4, `IPS_LIM_DIV4};
      default: expect_of = {`IPS_TYPE_UNKNOWN, `IPS_LIM_PIN};
    endcase
  endfunction

  // one plug-in through to converter start, then unplug
  task automatic plug_run(input logic [2:0] p);
    int n;
    int f;
    logic [9:0] e;
    e = expect_of(p);
    f = (p == 3'd0) ? 1 : ({$random(seed)} % 2);
    @(posedge clk);
    kind <= p;
    contact_dly <= 6'({$random(seed)} % 40);
    poor_source_ok <= (f == 0);
    input_uvlo_release <= 1'b1;
    adapter_present <= 1'b1;
    boost_mode <= (p == 3'd6);  // one kind runs the boost bias branch
    sleep_exit_margin <= (p != 3'd6);
    wt(0, n);
    chk("deb", n >= DEB && n <= DEB + 4, 1);
    wt(1, n);
    chk("bias_dly", n >= BIAS && n <= BIAS + 4, 1);
    repeat (f) begin
      wt(2, n);
      wt(5, n);
      chk("poor_len", n >= POOR - 1 && n <= POOR + 3, 1);
      chk("no_det",
          {input_source_good, dp_cur_src, converter_en}, 0);
      @(posedge clk);
      poor_source_ok <= 1'b1;
      wt(2, n);
      chk("retry", n >= RETRY - 2 && n <= RETRY + 4, 1);
    end
    wt(4, n);
    chk("good", input_source_good, 1);
    chk("type", adapter_type, e[9:6]);
    chk("limit", input_current_limit, e[5:0]);
    chk("vlim", input_voltage_limit_set, 1);
    if (p == 3'd3) begin
      @(posedge clk);
      input_surge <= 1'b1;
      @(negedge clk);
      chk("surge", {input_protect_switch, converter_en}, 0);
    end
    if (p == 3'd5) begin
      @(posedge clk);
      high_impedance_mode <= 1'b1;
      repeat (3) @(negedge clk);
      chk("hiz", bias_regulator, 0);
    end
    @(posedge clk);
    {adapter_present, input_uvlo_release, input_surge} <= 3'h0;
    high_impedance_mode <= 1'b0;
    repeat (5) @(negedge clk);
    chk("held", adapter_type, e[9:6]);
    chk("unplug", input_protect_switch, 0);
  endtask

  // main sequence
  initial begin
    seed = 32'h6843AAC3;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    chk("bat_sw", battery_switch, 1);
    chk("bias_idle", bias_regulator, 0);
    chk("bias_act", bias_active, 1);
    @(posedge clk);
    adapter_present <= 1'b1;
    adapter_overvoltage <= 1'b1;
    repeat (3 * DEB) @(negedge clk);
    chk("ovp", input_protect_switch, 0);
    @(posedge clk);
    {adapter_present, adapter_overvoltage} <= 2'h0;
    repeat (3) @(posedge clk);
    for (k = 0; k < 8; k++) plug_run(k[2:0]);
    @(posedge clk);
    discharge_overcurrent <= 1'b1;
    @(posedge clk);
    discharge_overcurrent <= 1'b0;
    repeat (10) @(negedge clk);
    chk("ocp", battery_switch, 0);
    // a fresh plug-in releases the overcurrent latch
    @(posedge clk);
    adapter_present <= 1'b1;
    repeat (3) @(negedge clk);
    chk("ocp_replug", battery_switch, 1);
    complete_run();
  end
endmodule
`default_nettype wire
